// >>> logic/ook_modem_mode_and_direction_control.sv
`timescale 1ns/10ps
`include "ook_modem_map.svh"
module ook_modem_mode_and_direction_control
  import ook_modem_pkg::*;
#(
  parameter int CNT_W = 18,
  parameter int DIR_SLOW_CYC = `DIR_SLOW_US * `CLK_MHZ,
  parameter int DIR_MID_CYC = `DIR_MID_US * `CLK_MHZ,
  parameter int DIR_FAST_CYC = `DIR_FAST_US * `CLK_MHZ
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Baseband
  input wire logic tx_bit_in_i,
  output logic rx_bit_out_o,
  // Coax
  input wire logic coax_rx_in_i,
  output logic coax_tx_out_o,
  // RS-485 direction
  output logic dir_o
);

  // ----------------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------------
  if (DIR_SLOW_CYC < 2 || DIR_MID_CYC < 2 || DIR_FAST_CYC < 2 ||
      DIR_SLOW_CYC >= (1 << CNT_W) || DIR_MID_CYC >= (1 << CNT_W) ||
      DIR_FAST_CYC >= (1 << CNT_W)) begin : g_bad_param
    $error("Direction timeout counts do not fit the counter.");
  end

  modem_path_if path ();

  logic [1:0] ctrl;
  logic rate_select_a;
  logic rate_select_b;
  logic standby_sel;
  mode_t state;
  mode_t next_state;
  logic [CNT_W-1:0] tmo_cnt;
  logic [CNT_W-1:0] tmo_lim;
  logic activity;
  logic wb_hit;
  logic [31:0] status;

  // ----------------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------------
  assign path.coax_in = coax_rx_in_i;
  assign path.fast_rate = rate_select_a | rate_select_b;

  carrier_detector u_det (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .path(path.detector)
  );

  carrier_nco u_nco (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .path(path.nco)
  );

  // ----------------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------------
  assign rate_select_a = ctrl[`CTRL_RATE_A];
  assign rate_select_b = ctrl[`CTRL_RATE_B];
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `CTRL_RESET;
    end else if (wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == `REG_CTRL) begin
      ctrl <= wb_dat_i[1:0];
    end
  end

  // ----------------------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------------------
  always_comb begin
    status = 32'h0000_0000;
    status[`ST_STANDBY] = (state == MODE_STANDBY);
    status[`ST_IDLE] = (state == MODE_IDLE);
    status[`ST_RECEIVE] = (state == MODE_RECEIVE);
    status[`ST_TRANSMIT] = (state == MODE_TRANSMIT);
    status[`ST_DIR] = dir_o;
    status[`ST_RX_BIT] = rx_bit_out_o;
    status[`ST_CARRIER] = path.carrier_valid;
    status[`ST_TX_OUT] = coax_tx_out_o;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_hit;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_hit) begin
      case (wb_adr_i)
        `REG_CTRL: begin
          wb_dat_o <= {30'h0000_0000, ctrl};
        end
        `REG_STATUS: begin
          wb_dat_o <= status;
        end
        default: begin
          wb_dat_o <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------------------
  // Standby select.
  assign standby_sel = rate_select_a & rate_select_b;

  always_comb begin
    next_state = state;
    if (standby_sel) begin
      next_state = MODE_STANDBY;
    end else begin
      case (state)
        MODE_STANDBY: begin
          next_state = MODE_IDLE;
        end
        MODE_IDLE: begin
          if (path.carrier_valid) begin
            next_state = MODE_RECEIVE;
          end else if (!tx_bit_in_i) begin
            next_state = MODE_TRANSMIT;
          end
        end
        MODE_RECEIVE: begin
          if (!path.carrier_valid && tmo_cnt == '0) begin
            next_state = MODE_IDLE;
          end
        end
        MODE_TRANSMIT: begin
          if (tx_bit_in_i && tmo_cnt == '0) begin
            next_state = MODE_IDLE;
          end
        end
        default: begin
          next_state = MODE_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= MODE_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------------------
  // Direction timeout
  // ----------------------------------------------------------------------------
  // Timeout chosen by rate select.
  always_comb begin
    if (rate_select_a && rate_select_b) begin
      tmo_lim = CNT_W'(DIR_FAST_CYC - 1);
    end else if (rate_select_a) begin
      tmo_lim = CNT_W'(DIR_MID_CYC - 1);
    end else begin
      tmo_lim = CNT_W'(DIR_SLOW_CYC - 1);
    end
  end

  // Receive tracks only the carrier, the other modes track a low host bit.
  assign activity = (state == MODE_RECEIVE) ? path.carrier_valid : !tx_bit_in_i;

  // Restart on each activity or mode change, count down after it ends.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmo_cnt <= '0;
    end else if (next_state != state || activity) begin
      tmo_cnt <= tmo_lim;
    end else if (tmo_cnt != '0) begin
      tmo_cnt <= tmo_cnt - 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_bit_out_o <= 1'b1;
    end else begin
      case (next_state)
        MODE_STANDBY, MODE_RECEIVE: begin
          rx_bit_out_o <= !path.carrier_valid;
        end
        default: begin
          rx_bit_out_o <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      coax_tx_out_o <= 1'b0;
    end else if (next_state == MODE_RECEIVE || next_state == MODE_TRANSMIT) begin
      coax_tx_out_o <= !tx_bit_in_i && path.carrier_wave;
    end else begin
      coax_tx_out_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_o <= 1'b0;
    end else begin
      dir_o <= (next_state == MODE_RECEIVE);
    end
  end

endmodule

// >>> logic/ook_modem_map.svh
`ifndef OOK_MODEM_MAP_SVH
`define OOK_MODEM_MAP_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define CLK_MHZ 32'h0000_007D
`define DIR_SLOW_US 32'h0000_0683
`define DIR_MID_US 32'h0000_01A1
`define DIR_FAST_US 32'h0000_0089
`define FILT_SLOW_US 32'h0000_0004
`define FILT_FAST_US 32'h0000_0002
`define FILT_SLOW_CYC (`FILT_SLOW_US * `CLK_MHZ)
`define FILT_FAST_CYC (`FILT_FAST_US * `CLK_MHZ)
`define EDGE_GAP_CYC 8'h40
`define NCO_STEP 32'h0474_D9C7

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define CTRL_RATE_A 0
`define CTRL_RATE_B 1
`define CTRL_RESET 2'h0
`define ST_STANDBY 0
`define ST_IDLE 1
`define ST_RECEIVE 2
`define ST_TRANSMIT 3
`define ST_DIR 4
`define ST_RX_BIT 5
`define ST_CARRIER 6
`define ST_TX_OUT 7

`endif

// >>> logic/ook_modem_pkg.sv
package ook_modem_pkg;
  typedef enum logic [1:0] {
    MODE_STANDBY,
    MODE_IDLE,
    MODE_RECEIVE,
    MODE_TRANSMIT
  } mode_t;
endpackage

// >>> logic/modem_path_if.sv
`timescale 1ns/10ps
interface modem_path_if;
  logic coax_in;
  logic fast_rate;
  logic carrier_valid;
  logic carrier_wave;
  modport detector (input coax_in, input fast_rate, output carrier_valid);
  modport nco (output carrier_wave);
  modport ctrl (output coax_in, output fast_rate, input carrier_valid, input carrier_wave);
endinterface

// >>> logic/carrier_nco.sv
`timescale 1ns/10ps
`include "ook_modem_map.svh"
module carrier_nco (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Carrier out
  modem_path_if.nco path
);
  logic [31:0] phase;

  // ----------------------------------------------------------------------------
  // Phase accumulator
  // ----------------------------------------------------------------------------
  // Carrier frequency synthesis.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase <= 32'h0000_0000;
    end else begin
      phase <= phase + `NCO_STEP;
    end
  end

  assign path.carrier_wave = phase[31];
endmodule

// >>> logic/carrier_detector.sv
`timescale 1ns/10ps
`include "ook_modem_map.svh"
module carrier_detector (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Coax side
  modem_path_if.detector path
);
  logic prev_in;
  logic [7:0] gap;
  logic raw_act;
  logic [9:0] filt;
  logic [9:0] filt_lim;
  logic valid;

  assign raw_act = (gap != `EDGE_GAP_CYC);
  assign filt_lim = path.fast_rate ? 10'(`FILT_FAST_CYC) : 10'(`FILT_SLOW_CYC);

  // ----------------------------------------------------------------------------
  // Edge gap measurement
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_in <= 1'b0;
      gap <= `EDGE_GAP_CYC;
    end else begin
      prev_in <= path.coax_in;
      if (path.coax_in != prev_in) begin
        gap <= 8'h00;
      end else if (gap != `EDGE_GAP_CYC) begin
        gap <= gap + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Noise filter
  // ----------------------------------------------------------------------------
  // Short bursts rejected.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt <= 10'h000;
      valid <= 1'b0;
    end else if (!raw_act) begin
      filt <= 10'h000;
      valid <= 1'b0;
    end else if (filt >= filt_lim) begin
      valid <= 1'b1;
    end else begin
      filt <= filt + 10'h001;
    end
  end

  assign path.carrier_valid = valid;
endmodule

// >>> verification/coax_remote.sv
`timescale 1ns/10ps
module coax_remote (
  // Clock
  input wire logic clk_i,
  // Control
  input wire logic send_i,
  // Coax
  output logic coax_o
);
  logic [4:0] div;
  logic ph;
  // Line is quiet outside a burst; about 2.2 MHz square wave inside.
  assign coax_o = send_i & ph;
  always_ff @(posedge clk_i) begin
    if (!send_i) begin
      div <= 5'h00;
      ph <= 1'b0;
    end else if (div == 5'h1b) begin
      div <= 5'h00;
      ph <= ~ph;
    end else begin
      div <= div + 5'h01;
    end
  end
endmodule

// >>> verification/ook_modem_properties.sv
`timescale 1ns/10ps
module ook_modem_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic tx_bit_in_i,
  input wire logic rx_bit_out_o,
  input wire logic coax_tx_out_o,
  input wire logic dir_o
);
  logic take;
  logic rd_st;
  logic rd_ct;
  logic [1:0] ctrl;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= 2'h0;
      rd_st <= 1'b0;
      rd_ct <= 1'b0;
    end else begin
      rd_st <= take && !wb_we_i && wb_adr_i == 4'h4;
      rd_ct <= take && !wb_we_i && wb_adr_i == 4'h0;
      if (take && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[0]) begin
        ctrl <= wb_dat_i[1:0];
      end
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_answer: assert property (take |=> wb_ack_o)
    else $error("ack missing");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_unmapped_zero: assert property (take && !wb_we_i && wb_adr_i != 4'h0
    && wb_adr_i != 4'h4 |=> wb_dat_o == 32'h0000_0000) else $error("unmapped data");
  a_ctrl_readback: assert property (rd_ct |-> wb_dat_o[1:0] == ctrl)
    else $error("ctrl readback");
  a_state_onehot: assert property (rd_st |-> $onehot(wb_dat_o[3:0]))
    else $error("state not onehot");
  a_standby_select: assert property (rd_st |-> wb_dat_o[0] == (ctrl == 2'h3))
    else $error("standby select");
  a_dir_receive: assert property (rd_st |-> wb_dat_o[4] == wb_dat_o[2])
    else $error("dir not receive");
  a_standby_quiet: assert property (rd_st && wb_dat_o[0] |-> !wb_dat_o[7])
    else $error("standby tx");
  a_idle_levels: assert property (rd_st && wb_dat_o[1] |-> wb_dat_o[5] && !wb_dat_o[7])
    else $error("idle levels");
  a_tx_rx_high: assert property (rd_st && wb_dat_o[3] |-> wb_dat_o[5])
    else $error("rx low in transmit");
  a_tx_quiet: assert property (tx_bit_in_i |=> !coax_tx_out_o)
    else $error("carrier while tx high");
  a_dir_on_rx: assert property ($rose(dir_o) |-> ##[0:3] !rx_bit_out_o)
    else $error("dir without rx");
  a_dir_release: assert property ($fell(dir_o) |-> rx_bit_out_o)
    else $error("dir dropped early");
endmodule
bind ook_modem_mode_and_direction_control ook_modem_properties i_props (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .tx_bit_in_i, .rx_bit_out_o, .coax_tx_out_o, .dir_o);

// >>> verification/ook_modem_mode_and_direction_control_tb.sv
`timescale 1ns/10ps
module ook_modem_mode_and_direction_control_tb;
  localparam int DS = 200;
  localparam int DM = 100;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, tx = 1'b1, send = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000, rd, dato, rv;
  logic ack, rx, coax_in, coax_out, dir;
  logic [1:0] ctl;
  int mismatches = 0, tests_run = 0, seed = 32'hb18c, n, k, lo, dt;
  initial forever #4 clk_i = ~clk_i;
  ook_modem_mode_and_direction_control #(.DIR_SLOW_CYC(DS), .DIR_MID_CYC(DM),
    .DIR_FAST_CYC(50)) i_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dato),
    .wb_ack_o(ack), .tx_bit_in_i(tx), .rx_bit_out_o(rx), .coax_rx_in_i(coax_in),
    .coax_tx_out_o(coax_out), .dir_o(dir));
  coax_remote i_far (.clk_i, .send_i(send), .coax_o(coax_in));
  // direction counts above are sized for the short test bursts.
  function automatic int dir_len(input int r);
    return (r == 1) ? DM : DS;
  endfunction
  // Any rate-select bit high selects the fast carrier filter.
  function automatic int flt_len(input int r);
    return (r == 0) ? 500 : 250;
  endfunction
  task automatic print_verdict;
    if (mismatches == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int t;
    t = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= d[7:4] | {3'h0, a == 4'h4};
    dat <= d;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && t < 20);
    if (ack !== 1'b1) begin
      mismatches++;
      $display("Error ack expected 1 seen %b", ack);
    end
    rd = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wait_on(input logic d, input logic v, input int lim);
    n = 0;
    while ((d ? dir : rx) !== v && n < lim) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  task automatic run(input int c);
    k = 0;
    lo = 0;
    repeat (c) begin
      @(posedge clk_i);
      k += int'(coax_out === 1'b1);
      lo += int'(rx === 1'b0);
    end
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, 4'h4, 32'h0000_0000);
    chk("status", 32'h0000_0022, rd);
    bus(1'b1, 4'h4, 32'hffff_ffff);
    bus(1'b0, 4'h8, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
    ctl = 2'h0;
    repeat (6) begin
      rv = $random(seed);
      bus(1'b1, 4'h0, rv);
      ctl = rv[4] ? rv[1:0] : ctl;
      bus(1'b0, 4'h0, 32'h0000_0000);
      chk("ctrl", {30'h0000_0000, ctl}, rd);
    end
    for (int r = 0; r < 3; r++) begin
      bus(1'b1, 4'h0, 32'h0000_00f0 | 32'(r));
      send <= 1'b1;
      run(flt_len(r) - 100 - ($random(seed) & 63));
      send <= 1'b0;
      chk("noise", 0, lo);
      run(200);
      send <= 1'b1;
      wait_on(1'b0, 1'b0, flt_len(r) + 100);
      wait_on(1'b1, 1'b1, 4);
      chk("dir", 1, 32'(dir));
      bus(1'b0, 4'h4, 32'h0000_0000);
      chk("rx_state", 32'h0000_0054, rd);
      tx <= 1'b0;
      run(100);
      tx <= 1'b1;
      chk("key", 1, 32'(k > 20 && k < 80));
      chk("follow", 100, lo);
      send <= 1'b0;
      wait_on(1'b0, 1'b1, 100);
      wait_on(1'b1, 1'b0, 400);
      dt = dir_len(r);
      chk("hold", 1, 32'(n >= dt - 4 && n <= dt + 4));
      bus(1'b0, 4'h4, 32'h0000_0000);
      chk("idle", 32'h0000_0022, rd);
    end
    tx <= 1'b0;
    run(40);
    send <= 1'b1;
    run(600);
    chk("tx_rx", 0, lo);
    chk("tx_key", 1, 32'(k > 200));
    bus(1'b0, 4'h4, 32'h0000_0000);
    chk("tx_state", 32'h0000_0028, rd & 32'h0000_003f);
    send <= 1'b0;
    run(100);
    tx <= 1'b1;
    run(DS - 10);
    bus(1'b0, 4'h4, 32'h0000_0000);
    chk("tx_hold", 32'h0000_0028, rd & 32'h0000_003f);
    run(20);
    bus(1'b0, 4'h4, 32'h0000_0000);
    chk("tx_end", 32'h0000_0022, rd);
    bus(1'b1, 4'h0, 32'h0000_00f3);
    send <= 1'b1;
    wait_on(1'b0, 1'b0, 700);
    chk("sb_rx", 0, 32'(rx));
    tx <= 1'b0;
    run(60);
    tx <= 1'b1;
    chk("sb_quiet", 0, k);
    bus(1'b0, 4'h4, 32'h0000_0000);
    chk("sb_state", 32'h0000_0041, rd);
    send <= 1'b0;
    bus(1'b1, 4'h0, 32'h0000_00f0);
    run(300);
    bus(1'b0, 4'h4, 32'h0000_0000);
    chk("sb_exit", 32'h0000_0022, rd);
    print_verdict;
  end
  initial begin
    #(8 * 40000);
    mismatches++;
    print_verdict;
  end
endmodule
